// ===== lcp_pkg.sv
// Package for the link configuration capability and power-up sequencer.
// Assumes a 200 MHz system clock; all times are turned into cycles here.
package lcp_pkg;

   // Clock rate and time bases
   localparam int unsigned CLK_MHZ = 200;
   localparam int unsigned CYC_PER_US = CLK_MHZ;
   localparam int unsigned CYC_PER_MS = CYC_PER_US * 1000;

   // Times as specified
   localparam int unsigned POR_MIN_MS = 2;
   localparam int unsigned POR_MAX_US = 6500;
   localparam int unsigned PERIPH_MAX_MS = 80;
   localparam int unsigned CAL_PERST_MIN_MS = 20;
   localparam int unsigned CAL_MIN_MS = 60;
   localparam int unsigned CAL_TYP_MS = 80;
   localparam int unsigned READY_MAX_MS = 120;
   localparam int unsigned TRAIN_MAX_MS = 20;
   localparam int unsigned L0_PERST_MAX_MS = 100;
   localparam int unsigned L0_POWER_MAX_MS = 200;

   // Cycle counts derived from the times (all above 4096, so top params)
   localparam int unsigned POR_MIN_CYC_D = POR_MIN_MS * CYC_PER_MS;
   localparam int unsigned POR_MAX_CYC_D = POR_MAX_US * CYC_PER_US;
   localparam int unsigned PERIPH_CYC_D = PERIPH_MAX_MS * CYC_PER_MS;
   localparam int unsigned CAL_PERST_CYC_D = CAL_PERST_MIN_MS * CYC_PER_MS;
   localparam int unsigned CAL_MIN_CYC_D = CAL_MIN_MS * CYC_PER_MS;
   localparam int unsigned CAL_TYP_CYC_D = CAL_TYP_MS * CYC_PER_MS;
   localparam int unsigned READY_CYC_D = READY_MAX_MS * CYC_PER_MS;
   localparam int unsigned TRAIN_CYC_D = TRAIN_MAX_MS * CYC_PER_MS;
   localparam int unsigned L0_PERST_CYC_D = L0_PERST_MAX_MS * CYC_PER_MS;
   localparam int unsigned L0_POWER_CYC_D = L0_POWER_MAX_MS * CYC_PER_MS;

   // Configuration-space byte offsets
   localparam logic [11:0] CAP_BASE_OFF = 12'hd00;
   localparam logic [11:0] CAP_LAST_OFF = 12'hd4c;
   localparam logic [11:0] EXT_CAP_HDR_OFF = 12'hd00;
   localparam logic [11:0] VND_CAP_HDR_OFF = 12'hd04;
   localparam logic [11:0] VND_SIG_OFF = 12'hd08;
   localparam logic [11:0] BOARD_ID_OFF = 12'hd1c;
   localparam logic [11:0] STATUS_OFF = 12'hd1e;

   // Header field values
   localparam logic [15:0] EXT_CAP_ID = 16'h000b;
   localparam logic [3:0] EXT_CAP_VER = 4'h1;
   localparam logic [3:0] VND_REV = 4'h0;
   localparam logic [11:0] VND_LEN = 12'h05c;
   localparam logic [15:0] BOARD_ID_RST = 16'h0000;

   // Status half-word field positions
   localparam int unsigned STAT_SHIFT = 8 * (STATUS_OFF - BOARD_ID_OFF);
   localparam int unsigned STAT_LIVE_BIT = 5;
   localparam int unsigned STAT_LOAD_BIT = 4;

   // Timing fault vector positions
   localparam int unsigned FLT_PERIPH = 0;
   localparam int unsigned FLT_READY = 1;
   localparam int unsigned FLT_CAL_PERST = 2;
   localparam int unsigned FLT_TRAIN = 3;
   localparam int unsigned FLT_L0_PERST = 4;
   localparam int unsigned FLT_L0_POWER = 5;
   localparam int unsigned FLT_W = 6;

   // Power-up sequencer states
   typedef enum logic [2:0] {
      ST_POR = 3'h0,
      ST_LOAD = 3'h1,
      ST_CAL = 3'h2,
      ST_WAIT_PERST = 3'h3,
      ST_TRAIN = 3'h4,
      ST_LINK_UP = 3'h5
   } lcp_state_t;

endpackage

// ===== lcp_sync2.sv
// Two-flop synchroniser for a group of independent level inputs.
// Assumes each bit is a slow level; multi-bit codes must be held stable.
`timescale 1ns/1ps
module lcp_sync2 #(
   parameter int unsigned WIDTH = 1
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic reset_n,
   // Levels
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_reg;

   // First stage feeds only the second stage
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         meta_reg <= '0;
         sync_out <= '0;
      end else begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end

endmodule

// ===== lcp_link_cap.sv
// Capability registers in configuration space plus power-up sequencing
// of the endpoint link. Assumes the config port is on clk_sys and all
// status pins come from other domains (synchronised here).
`timescale 1ns/1ps
module lcp_link_cap import lcp_pkg::*; #(
   parameter logic [11:0] NEXT_CAP_OFFSET = 12'h000,
   parameter logic [15:0] VENDOR_ID = 16'h5a5a,        // Arbitrary value
   parameter logic [31:0] VENDOR_SIGNATURE = 32'h5a5a0001, // Arbitrary value
   parameter logic [15:0] BOARD_ID = BOARD_ID_RST,
   parameter logic [2:0] QUAD_FAST_CODE = 3'h1,
   // Clock cycles per millisecond; a smaller value shortens every window alike
   parameter int unsigned CYCLES_PER_MS = CYC_PER_MS
) (
   // Clock and power-on reset
   input wire logic clk_sys,
   input wire logic reset_n,
   // Configuration read port
   input wire logic cfg_rd_req,
   input wire logic [11:0] cfg_addr,
   output logic cfg_rd_valid,
   output logic [31:0] cfg_rd_data,
   // Pins and control block status (asynchronous)
   input wire logic perst_n,
   input wire logic [2:0] boot_scheme_select,
   input wire logic periph_loaded,
   input wire logic xcvr_cal_done,
   input wire logic fabric_user_mode,
   input wire logic link_in_l0,
   input wire logic link_gen3,
   // Sequencing outputs
   output logic hard_reset_release,
   output logic xcvr_cal_active,
   output logic link_train_enable,
   output logic core_image_path,
   output logic app_traffic_enable,
   output logic link_load_enabled_flag,
   output logic fabric_live_flag,
   output logic [FLT_W-1:0] timing_fault
);

   // Whole state of the block
   typedef struct packed {
      lcp_state_t state;
      logic [31:0] phase_cnt;
      logic [31:0] up_cnt;
      logic [31:0] perst_cnt;
      logic perst_d;
      logic hard_rel;
      logic cal_act;
      logic load_en;
      logic live;
      logic train_en;
      logic img_path;
      logic app_en;
      logic [FLT_W-1:0] fault;
      logic rd_valid;
      logic [31:0] rd_data;
   } lcp_regs_t;

   lcp_regs_t q_reg;
   lcp_regs_t q_next;

   // All windows scale by one ratio, so their ordering can never be broken;
   // CYCLES_PER_MS must divide the clock rate evenly or SCALE rounds down and the windows run long
   localparam int unsigned SCALE = CYC_PER_MS / CYCLES_PER_MS;
   localparam int unsigned POR_MIN_CYC = POR_MIN_CYC_D / SCALE;
   localparam int unsigned POR_MAX_CYC = POR_MAX_CYC_D / SCALE;
   localparam int unsigned PERIPH_CYC = PERIPH_CYC_D / SCALE;
   localparam int unsigned CAL_PERST_CYC = CAL_PERST_CYC_D / SCALE;
   localparam int unsigned CAL_MIN_CYC = CAL_MIN_CYC_D / SCALE;
   localparam int unsigned CAL_TYP_CYC = CAL_TYP_CYC_D / SCALE;
   localparam int unsigned READY_CYC = READY_CYC_D / SCALE;
   localparam int unsigned TRAIN_CYC = TRAIN_CYC_D / SCALE;
   localparam int unsigned L0_PERST_CYC = L0_PERST_CYC_D / SCALE;
   localparam int unsigned L0_POWER_CYC = L0_POWER_CYC_D / SCALE;

   // Synchronised pin levels
   logic [8:0] pins_s;
   logic perst_s;
   logic [2:0] boot_s;
   logic periph_s;
   logic cal_done_s;
   logic live_s;
   logic l0_s;
   logic gen3_s;
   logic fast_sel;
   logic perst_rise;
   logic [15:0] status_hw;
   logic in_range;

   // All status inputs cross from foreign domains through two flops
   lcp_sync2 #(.WIDTH(9)) u_sync (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .async_in({perst_n, boot_scheme_select, periph_loaded, xcvr_cal_done,
                 fabric_user_mode, link_in_l0, link_gen3}),
      .sync_out(pins_s)
   );

   // Unpack the synchronised group
   assign perst_s = pins_s[8];
   assign boot_s = pins_s[7:5];
   assign periph_s = pins_s[4];
   assign cal_done_s = pins_s[3];
   assign live_s = pins_s[2];
   assign l0_s = pins_s[1];
   assign gen3_s = pins_s[0];
   assign fast_sel = (boot_s == QUAD_FAST_CODE);
   assign perst_rise = perst_s && !q_reg.perst_d;
   assign in_range = (cfg_addr >= CAP_BASE_OFF) && (cfg_addr <= CAP_LAST_OFF);

   // Status half-word that shares the board identifier dword
   always_comb begin
      status_hw = 16'h0000;
      status_hw[STAT_LIVE_BIT] = q_reg.live;
      status_hw[STAT_LOAD_BIT] = q_reg.load_en;
   end

   // Next-state logic for sequencer, flags and read port
   always_comb begin
      q_next = q_reg;
      q_next.perst_d = perst_s;
      q_next.rd_valid = cfg_rd_req;
      // Saturating counters so a long-idle link never wraps into a false pass
      if (q_reg.up_cnt != 32'hffffffff) begin
         q_next.up_cnt = q_reg.up_cnt + 32'h1;
      end
      if (!perst_s) begin
         q_next.perst_cnt = 32'h0;
      end else if (q_reg.perst_cnt != 32'hffffffff) begin
         q_next.perst_cnt = q_reg.perst_cnt + 32'h1;
      end
      q_next.phase_cnt = q_reg.phase_cnt + 32'h1;
      case (q_reg.state)
         ST_POR: begin
            // Fast boot takes the shortest legal delay, else the longest
            if ((fast_sel && (q_reg.phase_cnt + 32'h1 >= POR_MIN_CYC)) ||
                (q_reg.phase_cnt + 32'h1 >= POR_MAX_CYC)) begin
               q_next.state = ST_LOAD;
               q_next.phase_cnt = 32'h0;
            end
         end
         ST_LOAD: begin
            // Reset controller waits on the image, never on the platform reset
            if (periph_s) begin
               q_next.hard_rel = 1'b1;
               q_next.load_en = 1'b1;
               q_next.cal_act = 1'b1;
               q_next.state = ST_CAL;
               q_next.phase_cnt = 32'h0;
            end
         end
         ST_CAL: begin
            // Window ends at the later of the floor and the calibrator's done, or at the typical time without done
            if ((q_reg.phase_cnt + 32'h1 >= CAL_MIN_CYC) &&
                (cal_done_s || (q_reg.phase_cnt + 32'h1 >= CAL_TYP_CYC))) begin
               q_next.cal_act = 1'b0;
               q_next.state = ST_WAIT_PERST;
               q_next.phase_cnt = 32'h0;
            end
         end
         ST_WAIT_PERST: begin
            if (perst_s) begin
               q_next.train_en = 1'b1;
               q_next.state = ST_TRAIN;
               q_next.phase_cnt = 32'h0;
            end
         end
         ST_TRAIN: begin
            if (!perst_s) begin
               q_next.train_en = 1'b0;
               q_next.state = ST_WAIT_PERST;
            end else if (l0_s) begin
               q_next.state = ST_LINK_UP;
            end
         end
         ST_LINK_UP: begin
            // A new platform reset retrains without reloading the periphery
            if (!perst_s) begin
               q_next.train_en = 1'b0;
               q_next.state = ST_WAIT_PERST;
            end else if (!l0_s) begin
               q_next.state = ST_TRAIN;
            end
         end
         default: begin
            q_next.state = ST_POR;
            q_next.phase_cnt = 32'h0;
         end
      endcase
      // Fabric live is meaningful only once the periphery is up
      q_next.live = live_s && q_reg.load_en;
      // Link moves core image before user mode, application traffic after
      q_next.img_path = q_reg.load_en && !q_reg.live && l0_s &&
                        (q_reg.state == ST_LINK_UP);
      q_next.app_en = q_reg.live && l0_s && (q_reg.state == ST_LINK_UP);
      // Sticky timing faults, cleared only by power-on reset
      if ((q_reg.up_cnt == PERIPH_CYC) &&
          ((q_reg.state == ST_POR) || (q_reg.state == ST_LOAD))) begin
         q_next.fault[FLT_PERIPH] = 1'b1;
      end
      if ((q_reg.up_cnt == READY_CYC) && (q_reg.state <= ST_CAL)) begin
         q_next.fault[FLT_READY] = 1'b1;
      end
      if (perst_rise && ((q_reg.state <= ST_LOAD) ||
          ((q_reg.state == ST_CAL) && (q_reg.phase_cnt < CAL_PERST_CYC)))) begin
         q_next.fault[FLT_CAL_PERST] = 1'b1;
      end
      if ((q_reg.perst_cnt == TRAIN_CYC) && !q_reg.train_en) begin
         q_next.fault[FLT_TRAIN] = 1'b1;
      end
      if ((q_reg.perst_cnt == L0_PERST_CYC) && !gen3_s &&
          (q_reg.state != ST_LINK_UP)) begin
         q_next.fault[FLT_L0_PERST] = 1'b1;
      end
      if ((q_reg.up_cnt == L0_POWER_CYC) && (q_reg.state != ST_LINK_UP)) begin
         q_next.fault[FLT_L0_POWER] = 1'b1;
      end
      // Read port; unmapped words and words outside the range read zero
      q_next.rd_data = 32'h0;
      if (cfg_rd_req && in_range) begin
         case (cfg_addr[11:2])
            EXT_CAP_HDR_OFF[11:2]:
               q_next.rd_data = {NEXT_CAP_OFFSET, EXT_CAP_VER, EXT_CAP_ID};
            VND_CAP_HDR_OFF[11:2]:
               q_next.rd_data = {VND_LEN, VND_REV, VENDOR_ID};
            VND_SIG_OFF[11:2]:
               q_next.rd_data = VENDOR_SIGNATURE;
            BOARD_ID_OFF[11:2]:
               q_next.rd_data = {status_hw, BOARD_ID};
            default:
               q_next.rd_data = 32'h0;
         endcase
      end
   end

   // Single state register; configuration writes do not reach it
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         q_reg <= '0;
         q_reg.state <= ST_POR;
      end else begin
         q_reg <= q_next;
      end
   end

   // Outputs straight from the state register
   assign cfg_rd_valid = q_reg.rd_valid;
   assign cfg_rd_data = q_reg.rd_data;
   assign hard_reset_release = q_reg.hard_rel;
   assign xcvr_cal_active = q_reg.cal_act;
   assign link_train_enable = q_reg.train_en;
   assign core_image_path = q_reg.img_path;
   assign app_traffic_enable = q_reg.app_en;
   assign link_load_enabled_flag = q_reg.load_en;
   assign fabric_live_flag = q_reg.live;
   assign timing_fault = q_reg.fault;

   // Hard reset never releases ahead of the image-loaded flag
   a_hard_rel_gate: assert property (@(posedge clk_sys) disable iff (!reset_n)
      hard_reset_release |-> link_load_enabled_flag)
      else $error("hard reset released before load flag");

   // Platform reset assertion does not re-arm the hard reset
   a_perst_no_reset: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (hard_reset_release && $fell(perst_s)) |=> ##[0:3] hard_reset_release)
      else $error("platform reset dropped hard reset release");

   // Fast boot leaves the power-on delay inside its window
   a_por_window: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (q_reg.state == ST_POR && q_next.state == ST_LOAD && fast_sel) |->
      (q_reg.phase_cnt + 32'h1 >= POR_MIN_CYC) &&
      (q_reg.phase_cnt + 32'h1 <= POR_MAX_CYC))
      else $error("power-on delay outside window");

   // Calibration window never shorter than its floor
   a_cal_min_len: assert property (@(posedge clk_sys) disable iff (!reset_n)
      $fell(xcvr_cal_active) |-> ($past(q_reg.phase_cnt) + 32'h1 >= CAL_MIN_CYC))
      else $error("calibration window too short");

   // Training enable follows platform reset release after calibration
   a_train_prompt: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (q_reg.state == ST_WAIT_PERST && perst_s) |=> link_train_enable ##1
      (link_train_enable || !perst_s))
      else $error("training not enabled after reset release");

   // Late L0 after platform reset is flagged on Gen1 and Gen2
   a_l0_perst_late: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (q_reg.perst_cnt == L0_PERST_CYC && !gen3_s && q_reg.state != ST_LINK_UP)
      |=> timing_fault[FLT_L0_PERST])
      else $error("late link not flagged");

   // Late L0 from power-on is flagged
   a_l0_power_late: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (q_reg.up_cnt == L0_POWER_CYC && q_reg.state != ST_LINK_UP)
      |=> timing_fault[FLT_L0_POWER])
      else $error("late power-on link not flagged");

   // Load flag rises only on a loaded periphery
   a_load_flag_src: assert property (@(posedge clk_sys) disable iff (!reset_n)
      $rose(link_load_enabled_flag) |-> $past(periph_s) && $past(q_reg.state) == ST_LOAD)
      else $error("load flag without loaded image");

   // Every configuration read is answered one cycle later
   a_rd_answer: assert property (@(posedge clk_sys) disable iff (!reset_n)
      cfg_rd_req |=> cfg_rd_valid ##1 (cfg_rd_valid == $past(cfg_rd_req)))
      else $error("read not answered");

   // Capability header reads its fixed id and version
   a_cap_id_read: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (cfg_rd_req && cfg_addr == EXT_CAP_HDR_OFF) |=>
      (cfg_rd_data[15:0] == EXT_CAP_ID) && (cfg_rd_data[19:16] == EXT_CAP_VER))
      else $error("capability header mismatch");

   // Status half-word shows the live and load flags
   a_status_flags: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (cfg_rd_req && cfg_addr == BOARD_ID_OFF) |=>
      (cfg_rd_data[STAT_SHIFT + STAT_LIVE_BIT] == $past(fabric_live_flag)) &&
      (cfg_rd_data[STAT_SHIFT + STAT_LOAD_BIT] == $past(link_load_enabled_flag)))
      else $error("status flags mismatch");

   // Application traffic only in user mode
   a_app_user_mode: assert property (@(posedge clk_sys) disable iff (!reset_n)
      app_traffic_enable |-> $past(fabric_live_flag) && !core_image_path)
      else $error("application traffic outside user mode");

endmodule

// ===== lcp_host_model.sv
// Far-side model: root port holding platform reset, plus the control block,
// calibrator and link reporting load, calibration, L0 and user mode.
// Assumes the shortened cycle counts that the bench gives the design.
`timescale 1ns/1ps
module lcp_host_model #(
   parameter int unsigned PERST_MIN = 1000
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic reset_n,
   // Scenario knobs
   input wire logic [15:0] load_dly,
   input wire logic perst_drop,
   input wire logic go_user,
   input wire logic retrain,
   // Device side
   input wire logic hard_reset_release,
   input wire logic link_train_enable,
   output logic perst_n,
   output logic periph_loaded,
   output logic xcvr_cal_done,
   output logic link_in_l0,
   output logic fabric_user_mode
);
   logic [15:0] t_reg;
   logic [15:0] cal_reg;
   logic [15:0] trn_reg;
   // Timers since reset, since hard reset release and since training start
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         t_reg <= 16'h0000;
         cal_reg <= 16'h0000;
         trn_reg <= 16'h0000;
      end else begin
         t_reg <= (t_reg == 16'hffff) ? t_reg : t_reg + 16'h0001;
         cal_reg <= hard_reset_release ? cal_reg + {15'h0000, cal_reg != 16'hffff} : 16'h0000;
         trn_reg <= link_train_enable ? trn_reg + {15'h0000, trn_reg != 16'hffff} : 16'h0000;
      end
   end
   // Platform reset is never released before its minimum low time from reset release
   assign perst_n = reset_n && !perst_drop && (32'(t_reg) >= PERST_MIN);
   // Image loaded only by its own delay, never by platform reset
   assign periph_loaded = reset_n && (t_reg >= load_dly);
   assign xcvr_cal_done = cal_reg >= 16'h012c;
   // Retrain knocks the link out of L0 while the fabric stays configured
   assign link_in_l0 = (trn_reg >= 16'h0028) && !retrain;
   // User mode after the core image went over the live link
   assign fabric_user_mode = go_user && (trn_reg >= 16'h0028);
endmodule

// ===== tb_lcp_link_cap.sv
// Self-checking bench for the capability registers and power-up sequencer.
// Assumes the host model file and the shortened counts (10 cycles per ms).
`timescale 1ns/1ps
module tb_lcp_link_cap import lcp_pkg::*;;
   logic clk_sys = 1'b0;
   logic reset_n = 1'b0;
   logic cfg_rd_req = 1'b0;
   logic [11:0] cfg_addr = 12'h000;
   logic [2:0] strap = 3'h1;
   logic [15:0] load_dly = 16'h0064;
   logic perst_drop = 1'b0;
   logic go_user = 1'b0;
   logic gen3 = 1'b0;
   logic retrain = 1'b0;
   logic cfg_rd_valid, perst_n, periph_loaded, xcvr_cal_done, link_in_l0, fabric_user_mode;
   logic hard_reset_release, xcvr_cal_active, link_train_enable, core_image_path;
   logic app_traffic_enable, link_load_enabled_flag, fabric_live_flag;
   logic [31:0] cfg_rd_data;
   logic [FLT_W-1:0] timing_fault;
   int n_mismatch = 0;
   int n_checks = 0;
   int cyc, hr_at, cal_len;
   logic [11:0] adr [8] = '{12'hd00, 12'hd04, 12'hd08, 12'hd1c, 12'hd0c, 12'hd4c, 12'hd50, 12'hc00};
   logic [31:0] exv [8] = '{{12'h000, EXT_CAP_VER, EXT_CAP_ID}, {VND_LEN, VND_REV, 16'h5a5a},
      32'h5a5a0001, 32'h00000000, 32'h00000000, 32'h00000000, 32'h00000000, 32'h00000000};
   // Clock at 200 MHz
   always #2.5 clk_sys = ~clk_sys;
   // Cycle stamps: hard reset release time and calibration window length
   always @(posedge clk_sys) begin
      if (!reset_n) begin
         cyc <= 0;
         hr_at <= 0;
         cal_len <= 0;
      end else begin
         cyc <= cyc + 1;
         if (hard_reset_release === 1'b1 && hr_at == 0) hr_at <= cyc;
         if (xcvr_cal_active === 1'b1) cal_len <= cal_len + 1;
      end
   end
   lcp_link_cap #(.CYCLES_PER_MS(10)) u_lcp_link_cap (.clk_sys(clk_sys), .reset_n(reset_n),
      .cfg_rd_req(cfg_rd_req), .cfg_addr(cfg_addr), .cfg_rd_valid(cfg_rd_valid),
      .cfg_rd_data(cfg_rd_data), .perst_n(perst_n), .boot_scheme_select(strap),
      .periph_loaded(periph_loaded), .xcvr_cal_done(xcvr_cal_done),
      .fabric_user_mode(fabric_user_mode), .link_in_l0(link_in_l0), .link_gen3(gen3),
      .hard_reset_release(hard_reset_release), .xcvr_cal_active(xcvr_cal_active),
      .link_train_enable(link_train_enable), .core_image_path(core_image_path),
      .app_traffic_enable(app_traffic_enable), .link_load_enabled_flag(link_load_enabled_flag),
      .fabric_live_flag(fabric_live_flag), .timing_fault(timing_fault));
   lcp_host_model u_lcp_host_model (.clk_sys(clk_sys), .reset_n(reset_n), .load_dly(load_dly),
      .perst_drop(perst_drop), .go_user(go_user), .retrain(retrain),
      .hard_reset_release(hard_reset_release),
      .link_train_enable(link_train_enable), .perst_n(perst_n), .periph_loaded(periph_loaded),
      .xcvr_cal_done(xcvr_cal_done), .link_in_l0(link_in_l0),
      .fabric_user_mode(fabric_user_mode));
   task automatic test_done();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected value at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chk_rng(input int got, input int lo, input int hi);
      n_checks++;
      if (got < lo || got > hi) begin
         n_mismatch++;
         $display("unexpected count at %0t: got %h range %h %h", $time, got, lo, hi);
      end
   endtask
   // Release stamp lands one edge after the output rises, so let that edge pass
   task automatic chk_hr(input int lo, input int hi);
      @(posedge clk_sys);
      #1;
      chk_rng(hr_at, lo, hi);
   endtask
   function automatic logic pick(input int sel);
      case (sel)
         0: pick = hard_reset_release;
         1: pick = xcvr_cal_active;
         2: pick = link_train_enable;
         3: pick = core_image_path;
         default: pick = app_traffic_enable;
      endcase
   endfunction
   // Bounded wait for one sequencer output to reach a level
   task automatic wait_for(input int sel, input logic lvl, input int lim);
      int i;
      i = 0;
      while (pick(sel) !== lvl && i < lim) begin
         @(posedge clk_sys);
         #1;
         i++;
      end
      if (i >= lim) begin
         chk(32'(sel), 32'hffffffff);
         test_done();
      end
   endtask
   // One config read: request for one edge, answer one cycle later
   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      @(posedge clk_sys);
      #1;
      cfg_rd_req = 1'b1;
      cfg_addr = a;
      @(posedge clk_sys);
      #1;
      cfg_rd_req = 1'b0;
      chk({31'h0, cfg_rd_valid}, 32'h1);
      chk(cfg_rd_data, exp);
   endtask
   task automatic do_reset(input logic [2:0] s, input logic [15:0] ld);
      @(posedge clk_sys);
      #1;
      reset_n = 1'b0;
      strap = s;
      load_dly = ld;
      perst_drop = 1'b0;
      go_user = 1'b0;
      gen3 = 1'b0;
      retrain = 1'b0;
      repeat (12) @(posedge clk_sys);
      #1;
      reset_n = 1'b1;
   endtask
   initial begin
      do_reset(3'h1, 16'h0064);
      chk({26'h0, timing_fault}, 32'h0);
      for (int k = 0; k < 8; k++) rd(adr[k], exv[k]);
      wait_for(0, 1'b1, 2000);
      chk_hr(100, 110);
      rd(BOARD_ID_OFF, 32'h00100000);
      chk({31'h0, link_load_enabled_flag}, 32'h1);
      wait_for(1, 1'b0, 1000);
      chk_rng(cal_len, 600, 800);
      wait_for(3, 1'b1, 1500);
      chk({31'h0, app_traffic_enable}, 32'h0);
      go_user = 1'b1;
      wait_for(4, 1'b1, 50);
      rd(BOARD_ID_OFF, 32'h00300000);
      chk({31'h0, fabric_live_flag}, 32'h1);
      // Link below the Gen3 rate: the host knocks it out of L0 to retrain
      retrain = 1'b1;
      wait_for(4, 1'b0, 10);
      retrain = 1'b0;
      wait_for(4, 1'b1, 10);
      chk({31'h0, link_train_enable}, 32'h1);
      chk({31'h0, core_image_path}, 32'h0);
      chk({26'h0, timing_fault}, 32'h0);
      perst_drop = 1'b1;
      wait_for(2, 1'b0, 20);
      chk({31'h0, hard_reset_release}, 32'h1);
      // Power-on delay for both straps with the image ready at once
      do_reset(3'h1, 16'h0000);
      wait_for(0, 1'b1, 200);
      chk_hr(20, 26);
      do_reset(3'h0, 16'h0000);
      wait_for(0, 1'b1, 200);
      chk_hr(65, 71);
      // Late image: periphery and ready faults, reset released too early in calibration, training not enabled in time
      do_reset(3'h1, 16'h0384);
      wait_for(2, 1'b1, 3000);
      chk({26'h0, timing_fault}, 32'h0f);
      // Link held out of L0: late from power-on always, late after reset unless Gen3
      for (int g = 0; g < 2; g++) begin
         do_reset(3'h1, 16'h0000);
         gen3 = g[0];
         retrain = 1'b1;
         repeat (2010) @(posedge clk_sys);
         #1;
         chk({26'h0, timing_fault}, g ? 32'h20 : 32'h30);
      end
      test_done();
   end
endmodule
